// File: rtl/uep_dev.sv
// Purpose: endpoint zero OUT receive control with register slave and FIFO
// Assumes: host end keeps to the token order; link shares clk_i
// Notes: FIFO holds one packet; a packet arriving while one is pending is NAKed unless last data or oversize stalls it
//
// Added by the designer: the Avalon-MM register port and the address map.

`timescale 1ns/1ps

module uep_dev
  import uep_pkg::*;
#(
  parameter int MAX_PKT = EP0_MAX_PKT
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // link towards the host
  uep_link_if.dev link,
  // avalon-mm slave
  input wire logic [ADDR_W-1:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  // interrupt
  output logic irq_o
);

  localparam int CNT_W = $clog2(MAX_PKT) + 1;
  localparam int PTR_W = $clog2(MAX_PKT);
  localparam logic [CNT_W-1:0] MAX_CNT = CNT_W'(MAX_PKT);

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_DATA = 3'b010,
    ST_ANSWER = 3'b100
  } uep_dev_state_t;

  // ***************************************************************
  // state
  // ***************************************************************
  uep_dev_state_t state_q;
  logic [CNT_W-1:0] pkt_len_q;
  logic oversize_q;
  logic refuse_q;
  logic rx_mode_q;
  logic hs_vld_q;
  logic [1:0] hs_code_q;
  logic [7:0] fifo_q [MAX_PKT];
  logic [PTR_W-1:0] rd_ptr_q;
  logic [CNT_W-1:0] byte_cnt_q;
  logic opr_q;
  logic last_data_q;
  logic pse_q;
  logic stall_sent_q;
  logic [IRQ_W-1:0] irq_stat_q;
  logic [IRQ_W-1:0] irq_en_q;
  logic irq_q;
  logic wait_q;
  logic [31:0] rdata_q;

  logic acc_wr;
  logic acc_rd;
  logic end_good;
  logic accept;
  logic stall_now;
  logic early_end;
  logic stall_done;
  logic [IRQ_W-1:0] irq_set;

  // a write or a read takes effect on the edge where waitrequest is low
  assign acc_wr = avs_write_i && !wait_q;
  assign acc_rd = avs_read_i && !wait_q;
  assign end_good = (state_q == ST_DATA) && link.pkt_end;
  assign stall_now = end_good && (last_data_q || oversize_q);
  assign accept = end_good && !stall_now && !refuse_q;
  assign early_end = link.tok_vld && (link.tok_pid != PID_OUT) && rx_mode_q;
  assign stall_done = hs_vld_q && (hs_code_q == HS_STALL);
  assign irq_set = {early_end, stall_done, accept};

  // ***************************************************************
  // link sequencing
  // ***************************************************************
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_q <= ST_IDLE;
      pkt_len_q <= '0;
      oversize_q <= 1'b0;
      refuse_q <= 1'b0;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (link.tok_vld && link.tok_pid == PID_OUT) begin
            state_q <= ST_DATA;
            pkt_len_q <= '0;
            oversize_q <= 1'b0;
            // decided once per packet: a serviced write arriving mid-packet
            // must not accept a packet whose first bytes were dropped
            refuse_q <= opr_q;
          end
        end
        ST_DATA: begin
          if (link.pkt_end) begin
            state_q <= ST_ANSWER;
          end else if (link.dat_vld) begin
            if (pkt_len_q == MAX_CNT) begin
              oversize_q <= 1'b1;
            end else begin
              pkt_len_q <= pkt_len_q + 1'b1;
            end
          end
        end
        ST_ANSWER: begin
          state_q <= ST_IDLE;
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rx_mode_q <= 1'b0;
    end else if (link.tok_vld) begin
      rx_mode_q <= (link.tok_pid == PID_OUT);
    end else if (accept && pkt_len_q != MAX_CNT) begin
      rx_mode_q <= 1'b0;
    end
  end

  // handshake goes out the cycle after the packet end
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      hs_vld_q <= 1'b0;
      hs_code_q <= HS_ACK;
    end else begin
      hs_vld_q <= end_good;
      if (stall_now) begin
        hs_code_q <= HS_STALL;
      end else if (refuse_q) begin
        hs_code_q <= HS_NAK;
      end else begin
        hs_code_q <= HS_ACK;
      end
    end
  end

  assign link.hs_vld = hs_vld_q;
  assign link.hs_code = hs_code_q;

  // ***************************************************************
  // packet storage
  // ***************************************************************
  // bytes are only written for a packet not refused at its token, so firmware
  // never sees its data overwritten by a packet that will be NAKed
  always_ff @(posedge clk_i) begin
    if (state_q == ST_DATA && link.dat_vld && !refuse_q && pkt_len_q != MAX_CNT) begin
      fifo_q[pkt_len_q[PTR_W-1:0]] <= link.dat_byte;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      byte_cnt_q <= '0;
      rd_ptr_q <= '0;
    end else if (accept) begin
      byte_cnt_q <= pkt_len_q;
      rd_ptr_q <= '0;
    end else if (acc_rd && avs_address_i == ADDR_FIFO) begin
      rd_ptr_q <= rd_ptr_q + 1'b1;
    end
  end

  // ***************************************************************
  // control and status flags
  // ***************************************************************
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      opr_q <= 1'b0;
    end else if (accept) begin
      opr_q <= 1'b1;
    end else if (acc_wr && avs_address_i == ADDR_CSR && avs_writedata_i[CSR_SERVICED_BIT]) begin
      opr_q <= 1'b0;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      last_data_q <= 1'b0;
    end else if (link.tok_vld && link.tok_pid == PID_SETUP) begin
      last_data_q <= 1'b0;
    end else if (acc_wr && avs_address_i == ADDR_CSR && avs_writedata_i[CSR_LAST_BIT]) begin
      last_data_q <= 1'b1;
    end
  end

  // set wins over a write-one clear in the same cycle
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pse_q <= 1'b0;
      stall_sent_q <= 1'b0;
    end else begin
      if (early_end) begin
        pse_q <= 1'b1;
      end else if (acc_wr && avs_address_i == ADDR_CSR && avs_writedata_i[CSR_PSE_BIT]) begin
        pse_q <= 1'b0;
      end
      if (stall_done) begin
        stall_sent_q <= 1'b1;
      end else if (acc_wr && avs_address_i == ADDR_CSR && avs_writedata_i[CSR_STALL_BIT]) begin
        stall_sent_q <= 1'b0;
      end
    end
  end

  // ***************************************************************
  // interrupts
  // ***************************************************************
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      irq_stat_q <= IRQ_RST;
    end else if (acc_wr && avs_address_i == ADDR_IRQ_CLR) begin
      irq_stat_q <= (irq_stat_q & ~avs_writedata_i[IRQ_W-1:0]) | irq_set;
    end else begin
      irq_stat_q <= irq_stat_q | irq_set;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      irq_en_q <= IRQ_RST;
    end else if (acc_wr && avs_address_i == ADDR_IRQ_EN) begin
      irq_en_q <= avs_writedata_i[IRQ_W-1:0];
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= |(irq_stat_q & irq_en_q);
    end
  end

  assign irq_o = irq_q;

  // ***************************************************************
  // avalon-mm slave: one wait cycle, then the answer
  // ***************************************************************
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wait_q <= 1'b1;
    end else begin
      wait_q <= !(wait_q && (avs_read_i || avs_write_i));
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rdata_q <= RDATA_ZERO;
    end else if (avs_read_i && wait_q) begin
      rdata_q <= RDATA_ZERO;
      if (avs_address_i == ADDR_CSR) begin
        rdata_q[CSR_OPR_BIT] <= opr_q;
        rdata_q[CSR_STALL_BIT] <= stall_sent_q;
        rdata_q[CSR_LAST_BIT] <= last_data_q;
        rdata_q[CSR_PSE_BIT] <= pse_q;
        rdata_q[CSR_RXMODE_BIT] <= rx_mode_q;
      end else if (avs_address_i == ADDR_CNT) begin
        rdata_q[CNT_W-1:0] <= byte_cnt_q;
      end else if (avs_address_i == ADDR_FIFO) begin
        rdata_q[7:0] <= fifo_q[rd_ptr_q];
      end else if (avs_address_i == ADDR_IRQ_STAT) begin
        rdata_q[IRQ_W-1:0] <= irq_stat_q;
      end else if (avs_address_i == ADDR_IRQ_EN) begin
        rdata_q[IRQ_W-1:0] <= irq_en_q;
      end
    end
  end

  assign avs_waitrequest_o = wait_q;
  assign avs_readdata_o = rdata_q;

endmodule : uep_dev

// File: shared/uep_pkg.sv
// Purpose: shared constants for the endpoint zero OUT receive link and registers
// Assumes: one clock domain; byte-wide link between host end and device end
// Notes: register offsets are byte addresses on a 32-bit Avalon-MM slave

package uep_pkg;

  // ***************************************************************
  // link encodings
  // ***************************************************************
  localparam int EP0_MAX_PKT = 64;
  localparam logic [1:0] PID_OUT = 2'h0;
  localparam logic [1:0] PID_IN = 2'h1;
  localparam logic [1:0] PID_SETUP = 2'h2;
  localparam logic [1:0] HS_ACK = 2'h0;
  localparam logic [1:0] HS_NAK = 2'h1;
  localparam logic [1:0] HS_STALL = 2'h2;

  // ***************************************************************
  // register map
  // ***************************************************************
  localparam int ADDR_W = 5;
  localparam logic [4:0] ADDR_CSR = 5'h00;
  localparam logic [4:0] ADDR_CNT = 5'h04;
  localparam logic [4:0] ADDR_FIFO = 5'h08;
  localparam logic [4:0] ADDR_IRQ_STAT = 5'h0c;
  localparam logic [4:0] ADDR_IRQ_CLR = 5'h10;
  localparam logic [4:0] ADDR_IRQ_EN = 5'h14;

  // ep_zero_control_status fields
  localparam int CSR_OPR_BIT = 0;
  localparam int CSR_STALL_BIT = 2;
  localparam int CSR_LAST_BIT = 3;
  localparam int CSR_PSE_BIT = 4;
  localparam int CSR_SERVICED_BIT = 6;
  localparam int CSR_RXMODE_BIT = 7;

  // interrupt status / clear / enable fields
  localparam int IRQ_W = 3;
  localparam int IRQ_PKT_BIT = 0;
  localparam int IRQ_STALL_BIT = 1;
  localparam int IRQ_PSE_BIT = 2;
  localparam logic [2:0] IRQ_RST = 3'h0;
  localparam logic [31:0] RDATA_ZERO = 32'h0;

endpackage : uep_pkg

// File: shared/uep_link_if.sv
// Purpose: link between the host end and the endpoint zero device end
// Assumes: both ends on the same clock; every signal driven from a flip-flop
// Notes: tok_vld, pkt_end and hs_vld are one-cycle pulses; dat_vld is high for one cycle per byte

`timescale 1ns/1ps

interface uep_link_if (
  input wire logic clk_i,
  input wire logic rst_n_i
);
  logic tok_vld;
  logic [1:0] tok_pid;
  logic dat_vld;
  logic [7:0] dat_byte;
  logic pkt_end;
  logic hs_vld;
  logic [1:0] hs_code;

  modport host (
    output tok_vld, tok_pid, dat_vld, dat_byte, pkt_end,
    input hs_vld, hs_code
  );
  modport dev (
    input tok_vld, tok_pid, dat_vld, dat_byte, pkt_end,
    output hs_vld, hs_code
  );
endinterface : uep_link_if

// File: rtl/uep_host.sv
// Purpose: host end that drives endpoint zero OUT transfers and lone tokens
// Assumes: device answers every data packet with a handshake
// Notes: payload byte n of a transfer carries n modulo 256

`timescale 1ns/1ps

module uep_host
  import uep_pkg::*;
#(
  parameter int MAX_PKT = EP0_MAX_PKT
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // link towards the device
  uep_link_if.host link,
  // user command
  input wire logic cmd_vld_i,
  input wire logic [1:0] cmd_pid_i,
  input wire logic [15:0] cmd_len_i,
  // user status
  output logic busy_o,
  output logic done_o,
  output logic [1:0] result_o
);

  localparam logic [15:0] MAX_LEN = 16'(MAX_PKT);

  typedef enum logic [3:0] {
    HS_IDLE_ST = 4'b0001,
    HS_TOK_ST = 4'b0010,
    HS_DATA_ST = 4'b0100,
    HS_WAIT_ST = 4'b1000
  } uep_host_state_t;

  function automatic logic [15:0] pkt_size(input logic [15:0] rem);
    pkt_size = (rem > MAX_LEN) ? MAX_LEN : rem;
  endfunction : pkt_size

  uep_host_state_t state_q;
  logic [15:0] rem_q;
  logic [15:0] off_q;
  logic [15:0] size_q;
  logic [15:0] idx_q;
  logic tok_vld_q;
  logic [1:0] tok_pid_q;
  logic dat_vld_q;
  logic [7:0] dat_byte_q;
  logic pkt_end_q;
  logic busy_q;
  logic done_q;
  logic [1:0] result_q;

  // ***************************************************************
  // transfer sequencing
  // ***************************************************************
  // packets keep coming until one shorter than the maximum is ACKed or one is stalled, so a length
  // that is an exact multiple ends with an empty packet
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_q <= HS_IDLE_ST;
      rem_q <= '0;
      off_q <= '0;
      size_q <= '0;
      idx_q <= '0;
      tok_vld_q <= 1'b0;
      tok_pid_q <= PID_OUT;
      dat_vld_q <= 1'b0;
      dat_byte_q <= '0;
      pkt_end_q <= 1'b0;
      busy_q <= 1'b0;
      done_q <= 1'b0;
      result_q <= HS_ACK;
    end else begin
      tok_vld_q <= 1'b0;
      dat_vld_q <= 1'b0;
      pkt_end_q <= 1'b0;
      done_q <= 1'b0;
      case (state_q)
        HS_IDLE_ST: begin
          if (cmd_vld_i) begin
            if (cmd_pid_i == PID_OUT) begin
              rem_q <= cmd_len_i;
              off_q <= '0;
              busy_q <= 1'b1;
              state_q <= HS_TOK_ST;
            end else begin
              tok_vld_q <= 1'b1;
              tok_pid_q <= cmd_pid_i;
              done_q <= 1'b1;
            end
          end
        end
        HS_TOK_ST: begin
          tok_vld_q <= 1'b1;
          tok_pid_q <= PID_OUT;
          size_q <= pkt_size(rem_q);
          idx_q <= '0;
          state_q <= HS_DATA_ST;
        end
        HS_DATA_ST: begin
          if (idx_q != size_q) begin
            dat_vld_q <= 1'b1;
            dat_byte_q <= 8'(off_q + idx_q);
            idx_q <= idx_q + 1'b1;
          end else begin
            pkt_end_q <= 1'b1;
            state_q <= HS_WAIT_ST;
          end
        end
        HS_WAIT_ST: begin
          if (link.hs_vld) begin
            result_q <= link.hs_code;
            if (link.hs_code == HS_NAK) begin
              state_q <= HS_TOK_ST;
            end else if (link.hs_code == HS_ACK && size_q == MAX_LEN) begin
              rem_q <= rem_q - size_q;
              off_q <= off_q + size_q;
              state_q <= HS_TOK_ST;
            end else begin
              busy_q <= 1'b0;
              done_q <= 1'b1;
              state_q <= HS_IDLE_ST;
            end
          end
        end
        default: begin
          state_q <= HS_IDLE_ST;
        end
      endcase
    end
  end

  assign link.tok_vld = tok_vld_q;
  assign link.tok_pid = tok_pid_q;
  assign link.dat_vld = dat_vld_q;
  assign link.dat_byte = dat_byte_q;
  assign link.pkt_end = pkt_end_q;
  assign busy_o = busy_q;
  assign done_o = done_q;
  assign result_o = result_q;

endmodule : uep_host

// File: test/uep_checker.sv
// Purpose: link checker for endpoint zero OUT traffic between host end and device end
// Assumes: both ends share clk_i and use the same MAX_PKT
// Notes: only link signals are visible here, so register flags are judged by the bench

`timescale 1ns/1ps

module uep_checker
  import uep_pkg::*;
#(
  parameter int MAX_PKT = EP0_MAX_PKT
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // link
  input wire logic tok_vld,
  input wire logic [1:0] tok_pid,
  input wire logic dat_vld,
  input wire logic [7:0] dat_byte,
  input wire logic pkt_end,
  input wire logic hs_vld,
  input wire logic [1:0] hs_code
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  // ******************
  // helpers
  // ******************
  logic [15:0] cnt_q;
  logic lock_q;

  // bytes since the last token
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) cnt_q <= 16'h0;
    else if (tok_vld) cnt_q <= 16'h0;
    else if (dat_vld) cnt_q <= cnt_q + 16'h1;
  end

  // no oversize packets on this link, so any stall here came from last-data
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) lock_q <= 1'b0;
    else if (tok_vld && tok_pid == PID_SETUP) lock_q <= 1'b0;
    else if (hs_vld && hs_code == HS_STALL) lock_q <= 1'b1;
  end

  // ******************
  // assertions
  // ******************
  sequence s_pkt_close;
    pkt_end ##1 hs_vld;
  endsequence
  sequence s_full_ack;
    (pkt_end && cnt_q == MAX_PKT) ##1 (hs_vld && hs_code == HS_ACK);
  endsequence

  chk_hs_after_end: assert property (pkt_end |=> hs_vld)
    else $error("no handshake after packet end");
  chk_hs_has_cause: assert property (hs_vld |-> $past(pkt_end))
    else $error("handshake without packet end");
  chk_hs_single: assert property (s_pkt_close |=> !hs_vld)
    else $error("handshake longer than one cycle");
  chk_stall_sticky: assert property (hs_vld && lock_q |-> hs_code == HS_STALL)
    else $error("packet after last data not stalled");
  chk_oversize_stall: assert property (pkt_end && cnt_q > MAX_PKT |=> hs_vld && hs_code == HS_STALL)
    else $error("oversize packet not stalled");
  chk_pkt_size: assert property (dat_vld |-> cnt_q < MAX_PKT)
    else $error("host packet above maximum size");
  chk_tok_alone: assert property (tok_vld |-> !dat_vld && !pkt_end && !hs_vld)
    else $error("token overlaps data or handshake");
  chk_full_continues: assert property (s_full_ack |=> ##[0:32] (tok_vld && tok_pid == PID_OUT))
    else $error("full packet not followed by another packet");
endmodule : uep_checker

// File: test/usb_ep0_out_receive_control_tb.sv
// Purpose: self-checking bench for endpoint zero OUT receive, both ends in design code
// Assumes: slave answers every access; host end retries NAKed packets by itself
// Notes: a second device on a bench-driven link takes the oversize packet

`timescale 1ns/1ps

module usb_ep0_out_receive_control_tb
  import uep_pkg::*;
;
  localparam int MPKT = 8;
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic [4:0] avs_address_i = 5'h00;
  logic avs_read_i = 1'b0;
  logic avs_write_i = 1'b0;
  logic [31:0] avs_writedata_i = 32'h0;
  logic [31:0] avs_readdata_o;
  logic avs_waitrequest_o;
  logic irq_o;
  logic cmd_vld_i = 1'b0;
  logic [1:0] cmd_pid_i = 2'h0;
  logic [15:0] cmd_len_i = 16'h0;
  logic busy_o;
  logic done_o;
  logic [1:0] result_o;
  int n_errors = 0;
  int cmp_count = 0;
  int lens [2] = '{MPKT, MPKT + 3};
  logic [1:0] pids [2] = '{PID_IN, PID_SETUP};
  logic [31:0] csr_exp [2] = '{32'h1c, 32'h14};
  logic [4:0] rst_addr [5] = '{ADDR_CSR, ADDR_CNT, ADDR_IRQ_STAT, ADDR_IRQ_EN, 5'h1c};

  initial begin
    forever #2 clk_i = ~clk_i;
  end

  // ******************
  // design
  // ******************
  uep_link_if link_a (.clk_i(clk_i), .rst_n_i(rst_n_i));
  uep_link_if link_b (.clk_i(clk_i), .rst_n_i(rst_n_i));

  uep_dev #(.MAX_PKT(MPKT)) i_uep_dev (.clk_i(clk_i), .rst_n_i(rst_n_i), .link(link_a),
    .avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
    .avs_writedata_i(avs_writedata_i), .avs_readdata_o(avs_readdata_o),
    .avs_waitrequest_o(avs_waitrequest_o), .irq_o(irq_o));
  uep_host #(.MAX_PKT(MPKT)) i_uep_host (.clk_i(clk_i), .rst_n_i(rst_n_i), .link(link_a),
    .cmd_vld_i(cmd_vld_i), .cmd_pid_i(cmd_pid_i), .cmd_len_i(cmd_len_i), .busy_o(busy_o),
    .done_o(done_o), .result_o(result_o));
  // second device only sees bench traffic; its register side is left idle
  uep_dev #(.MAX_PKT(MPKT)) i_uep_dev_b (.clk_i(clk_i), .rst_n_i(rst_n_i), .link(link_b),
    .avs_address_i(5'h00), .avs_read_i(1'b0), .avs_write_i(1'b0), .avs_writedata_i(32'h0),
    .avs_readdata_o(), .avs_waitrequest_o(), .irq_o());
  uep_checker #(.MAX_PKT(MPKT)) i_uep_checker (.clk_i(clk_i), .rst_n_i(rst_n_i),
    .tok_vld(link_a.tok_vld), .tok_pid(link_a.tok_pid), .dat_vld(link_a.dat_vld),
    .dat_byte(link_a.dat_byte), .pkt_end(link_a.pkt_end), .hs_vld(link_a.hs_vld),
    .hs_code(link_a.hs_code));

  // ******************
  // tasks
  // ******************
  task complete_run;
    if (n_errors == 0 && cmp_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : complete_run

  task give_up;
    n_errors++;
    $display("[FAIL] %0t wait timed out", $time);
    complete_run();
  endtask : give_up

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] %0t got %h want %h", $time, seen, exp);
    end
  endtask : chk

  task av(input logic wr, input logic [4:0] a, input logic [31:0] wd, output logic [31:0] rd);
    int n;
    n = 0;
    @(posedge clk_i);
    avs_address_i <= a;
    avs_write_i <= wr;
    avs_read_i <= !wr;
    avs_writedata_i <= wd;
    do begin
      @(posedge clk_i);
      n++;
      if (n > 50) give_up();
    end while (avs_waitrequest_o !== 1'b0);
    rd = avs_readdata_o;
    avs_read_i <= 1'b0;
    avs_write_i <= 1'b0;
  endtask : av

  task wr(input logic [4:0] a, input logic [31:0] d);
    logic [31:0] x;
    av(1'b1, a, d, x);
  endtask : wr

  task rdc(input logic [4:0] a, input logic [31:0] e);
    logic [31:0] d;
    av(1'b0, a, 32'h0, d);
    chk(d, e);
  endtask : rdc

  task fifo_chk(input int first, input int n);
    logic [31:0] d;
    for (int i = 0; i < n; i++) begin
      av(1'b0, ADDR_FIFO, 32'h0, d);
      chk({24'h0, d[7:0]}, 32'(first + i));
    end
  endtask : fifo_chk

  task go(input logic [1:0] p, input int l);
    @(posedge clk_i);
    cmd_vld_i <= 1'b1;
    cmd_pid_i <= p;
    cmd_len_i <= 16'(l);
    @(posedge clk_i);
    cmd_vld_i <= 1'b0;
  endtask : go

  task wait_done;
    int n;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
      if (n > 2000) give_up();
    end while (done_o !== 1'b1);
  endtask : wait_done

  task wait_irq;
    int n;
    n = 0;
    while (irq_o !== 1'b1) begin
      @(posedge clk_i);
      n++;
      if (n > 400) give_up();
    end
  endtask : wait_irq

  // ******************
  // sequence
  // ******************
  initial begin
    link_b.tok_vld = 1'b0;
    link_b.tok_pid = PID_OUT;
    link_b.dat_vld = 1'b0;
    link_b.dat_byte = 8'h5a;
    link_b.pkt_end = 1'b0;
    repeat (20) @(posedge clk_i);
    rst_n_i <= 1'b1;
    foreach (rst_addr[i]) rdc(rst_addr[i], 32'h0);
    chk({31'h0, irq_o}, 32'h0);
    wr(ADDR_IRQ_EN, 32'h7);
    rdc(ADDR_IRQ_EN, 32'h7);
    // a full packet, then a zero-length or a short one
    foreach (lens[k]) begin
      go(PID_OUT, lens[k]);
      wait_irq();
      chk({31'h0, busy_o}, 32'h1);
      rdc(ADDR_CSR, 32'h81);
      rdc(ADDR_CNT, MPKT);
      fifo_chk(0, MPKT);
      wr(ADDR_IRQ_CLR, 32'h1);
      wr(ADDR_CSR, 32'h40);
      wait_done();
      chk({30'h0, result_o}, {30'h0, HS_ACK});
      chk({31'h0, busy_o}, 32'h0);
      rdc(ADDR_CSR, 32'h01);
      chk({31'h0, irq_o}, 32'h1);
      rdc(ADDR_CNT, lens[k] - MPKT);
      fifo_chk(MPKT, lens[k] - MPKT);
      wr(ADDR_CSR, 32'h40);
      wr(ADDR_IRQ_CLR, 32'h1);
      rdc(ADDR_CSR, 32'h0);
      chk({31'h0, irq_o}, 32'h0);
    end
    // stall after last data, then an early token of each kind
    foreach (pids[k]) begin
      wr(ADDR_CSR, 32'h08);
      go(PID_OUT, 1);
      wait_done();
      chk({30'h0, result_o}, {30'h0, HS_STALL});
      rdc(ADDR_CSR, 32'h8c);
      go(pids[k], 0);
      wait_done();
      rdc(ADDR_CSR, csr_exp[k]);
      wr(ADDR_CSR, 32'h14);
    end
    rdc(ADDR_CSR, 32'h0);
    rdc(ADDR_IRQ_STAT, 32'h6);
    chk({31'h0, irq_o}, 32'h1);
    wr(ADDR_IRQ_EN, 32'h1);
    rdc(ADDR_IRQ_STAT, 32'h6);
    chk({31'h0, irq_o}, 32'h0);
    wr(ADDR_IRQ_CLR, 32'h6);
    rdc(ADDR_IRQ_STAT, 32'h0);
    wr(5'h1c, 32'hffff_ffff);
    rdc(5'h1c, 32'h0);
    // one byte beyond the maximum on the bench-driven link
    @(posedge clk_i);
    link_b.tok_vld <= 1'b1;
    @(posedge clk_i);
    link_b.tok_vld <= 1'b0;
    link_b.dat_vld <= 1'b1;
    repeat (MPKT + 1) @(posedge clk_i);
    link_b.dat_vld <= 1'b0;
    link_b.pkt_end <= 1'b1;
    @(posedge clk_i);
    link_b.pkt_end <= 1'b0;
    @(posedge clk_i);
    chk({29'h0, link_b.hs_vld, link_b.hs_code}, {29'h0, 1'b1, HS_STALL});
    complete_run();
  end
endmodule : usb_ep0_out_receive_control_tb
